// ===== core/ttfs_pkg.sv
/*
  Constants for the timer toggle, flags and snapshot block.
  Assumes APB with 32-bit data; offsets are byte addresses.
*/
package ttfs_pkg;
  localparam logic [7:0]  OFF_FLOP_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_STATUS      = 8'h04;
  localparam logic [7:0]  OFF_IRQ_EN      = 8'h08;
  localparam logic [7:0]  OFF_SNAPSHOT    = 8'h0c;
  localparam logic [7:0]  OFF_COMPARE0    = 8'h10;
  localparam logic [7:0]  OFF_COMPARE1    = 8'h14;
  localparam logic [7:0]  OFF_INT_MASK    = 8'h18;
  localparam int          BIT_CAP1_TGL    = 5;
  localparam int          BIT_CAP0_TGL    = 4;
  localparam int          BIT_CMP1_TGL    = 3;
  localparam int          BIT_CMP0_TGL    = 2;
  localparam int          BIT_OVF         = 2;
  localparam int          BIT_CMP1        = 1;
  localparam int          BIT_CMP0        = 0;
  localparam logic [1:0]  CMD_INVERT      = 2'h0;
  localparam logic [1:0]  CMD_SET         = 2'h1;
  localparam logic [1:0]  CMD_CLEAR       = 2'h2;
  localparam logic [1:0]  CMD_READBACK    = 2'h3;
  localparam logic [1:0]  CTRL_HIGH_BITS  = 2'h3;
  localparam logic [3:0]  RST_TOGGLE_EN   = 4'h0;
  localparam logic [2:0]  RST_IRQ_EN      = 3'h0;
  localparam logic [2:0]  RST_INT_MASK    = 3'h7;
  localparam logic [15:0] RST_COMPARE     = 16'h0000;
  localparam logic        RST_FLOP        = 1'b0;
  localparam logic [2:0]  RST_STATUS      = 3'h0;
  localparam logic        RST_IRQ         = 1'b0;
endpackage

// ===== core/ttfs_top.sv
/*
  Timer channel toggle flop, event flags, interrupt and counter snapshot.
  Assumes counter, capture-load and overflow strobes are synchronous to CLK
  and one cycle wide; APB slave answers with zero wait states.
*/
// What this block does
// R01: Capture-one load inverts output flop when its toggle enable is set.
// R02: Capture-zero load inverts output flop when its toggle enable is set.
// R03: Counter equal to compare one inverts flop when enabled.
// R04: Counter equal to compare zero inverts flop when enabled.
// R05: Flop command 00 inverts, 01 sets, 10 clears, 11 keeps.
// R06: Flop command field is not stored and reads as 11.
// R07: Overflow sets status bit 2.
// R08: Match with compare one sets status bit 1.
// R09: Match with compare zero sets status bit 0.
// R10: Reading status clears its flags; writes do not clear.
// R11: Flags set regardless of interrupt enables.
// R12: Interrupt requested only for events whose enable bit is set.
// R13: Snapshot read returns live counter value in bits 15-0.
// R14: Two 16-bit compare registers continuously compared with the counter.
// R15: Coincident toggles change flop once; software set or clear wins.
// R16: Event coinciding with clearing status read stays set.
`timescale 1ns/1ps
`default_nettype none
module ttfs_top #(
  parameter int CNT_W = 16
) (
  input  wire logic             CLK,
  input  wire logic             RST_N,
  input  wire logic             CLK_EN,
  input  wire logic [CNT_W-1:0] COUNTER,
  input  wire logic             CAPTURE0_LOAD,
  input  wire logic             CAPTURE1_LOAD,
  input  wire logic             OVERFLOW,
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [7:0]       PADDR,
  input  wire logic [31:0]      PWDATA,
  output logic [31:0]           PRDATA,
  output logic                  PREADY,
  output logic                  PSLVERR,
  output logic                  TIMER_OUT,
  output logic                  MATCH0,
  output logic                  MATCH1,
  output logic                  IRQ
);
  logic [3:0]       toggle_en_reg;
  logic [2:0]       irq_en_reg;
  logic [2:0]       int_mask_reg;
  logic [2:0]       status_reg;
  logic [2:0]       status_next;
  logic [CNT_W-1:0] compare0_reg;
  logic [CNT_W-1:0] compare1_reg;
  logic             flop_reg;
  logic             flop_next;
  logic             wr_en;
  logic             rd_en;
  logic             hit_ctrl;
  logic             hit_stat;
  logic             hit_ien;
  logic             hit_snap;
  logic             hit_cmp0;
  logic             hit_cmp1;
  logic             hit_mask;
  logic             mapped;
  logic             match0;
  logic             match1;
  logic [2:0]       events;
  logic             toggle_any;
  logic [31:0]      rdata_mux;

  assign wr_en = CLK_EN && PSEL && PENABLE && PWRITE;
  assign rd_en = CLK_EN && PSEL && PENABLE && !PWRITE;

  // Address decode
  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_ien  = 1'b0;
    hit_snap = 1'b0;
    hit_cmp0 = 1'b0;
    hit_cmp1 = 1'b0;
    hit_mask = 1'b0;
    if (PADDR == ttfs_pkg::OFF_FLOP_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (PADDR == ttfs_pkg::OFF_STATUS) begin
      hit_stat = 1'b1;
    end else if (PADDR == ttfs_pkg::OFF_IRQ_EN) begin
      hit_ien = 1'b1;
    end else if (PADDR == ttfs_pkg::OFF_SNAPSHOT) begin
      hit_snap = 1'b1;
    end else if (PADDR == ttfs_pkg::OFF_COMPARE0) begin
      hit_cmp0 = 1'b1;
    end else if (PADDR == ttfs_pkg::OFF_COMPARE1) begin
      hit_cmp1 = 1'b1;
    end else if (PADDR == ttfs_pkg::OFF_INT_MASK) begin
      hit_mask = 1'b1;
    end
  end

  assign mapped  = hit_ctrl | hit_stat | hit_ien | hit_snap | hit_cmp0 | hit_cmp1 | hit_mask;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // Compare registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      compare0_reg <= CNT_W'(ttfs_pkg::RST_COMPARE);
      compare1_reg <= CNT_W'(ttfs_pkg::RST_COMPARE);
    end else if (wr_en) begin
      if (hit_cmp0) begin
        compare0_reg <= PWDATA[CNT_W-1:0]; // R14
      end
      if (hit_cmp1) begin
        compare1_reg <= PWDATA[CNT_W-1:0]; // R14
      end
    end
  end

  assign match0 = (COUNTER == compare0_reg); // R14
  assign match1 = (COUNTER == compare1_reg); // R14
  assign MATCH0 = match0;
  assign MATCH1 = match1;

  // Control and enable registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      toggle_en_reg <= ttfs_pkg::RST_TOGGLE_EN;
      irq_en_reg    <= ttfs_pkg::RST_IRQ_EN;
      int_mask_reg  <= ttfs_pkg::RST_INT_MASK;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        toggle_en_reg <= PWDATA[ttfs_pkg::BIT_CAP1_TGL:ttfs_pkg::BIT_CMP0_TGL];
      end
      if (hit_ien) begin
        irq_en_reg <= PWDATA[2:0];
      end
      if (hit_mask) begin
        int_mask_reg <= PWDATA[2:0];
      end
    end
  end

  // Toggle flop: one change per cycle, software set or clear first
  always_comb begin
    // OR, not XOR: coincident toggles must still change the flop once
    toggle_any = (toggle_en_reg[3] && CAPTURE1_LOAD)  // R01
               || (toggle_en_reg[2] && CAPTURE0_LOAD) // R02
               || (toggle_en_reg[1] && match1)        // R03
               || (toggle_en_reg[0] && match0);       // R04
    flop_next = toggle_any ? !flop_reg : flop_reg; // R15
    if (wr_en && hit_ctrl) begin
      case (PWDATA[1:0])
        ttfs_pkg::CMD_SET:    flop_next = 1'b1; // R05 R15
        ttfs_pkg::CMD_CLEAR:  flop_next = 1'b0; // R05 R15
        ttfs_pkg::CMD_INVERT: flop_next = !flop_reg; // R05 R15
        default:              flop_next = flop_next; // R05
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flop_reg <= ttfs_pkg::RST_FLOP;
    end else if (CLK_EN) begin
      flop_reg <= flop_next;
    end
  end

  assign TIMER_OUT = flop_reg;

  // Status flags: events win over the clearing read
  assign events = {OVERFLOW, match1, match0}; // R07 R08 R09 R11

  always_comb begin
    status_next = status_reg;
    if (rd_en && hit_stat) begin
      status_next = 3'h0; // R10
    end
    status_next = status_next | events; // R16
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_reg <= ttfs_pkg::RST_STATUS;
    end else if (CLK_EN) begin
      status_reg <= status_next;
    end
  end

  // Level interrupt: enable and mask both gate, never the flag
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= ttfs_pkg::RST_IRQ;
    end else if (CLK_EN) begin
      IRQ <= |(status_next & irq_en_reg & int_mask_reg); // R12
    end
  end

  // Read mux; snapshot is the live counter
  always_comb begin
    rdata_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_mux[7:6] = ttfs_pkg::CTRL_HIGH_BITS;
      rdata_mux[5:2] = toggle_en_reg;
      rdata_mux[1:0] = ttfs_pkg::CMD_READBACK; // R06
    end else if (hit_stat) begin
      rdata_mux[2:0] = status_reg;
    end else if (hit_ien) begin
      rdata_mux[2:0] = irq_en_reg;
    end else if (hit_snap) begin
      rdata_mux[CNT_W-1:0] = COUNTER; // R13
    end else if (hit_cmp0) begin
      rdata_mux[CNT_W-1:0] = compare0_reg;
    end else if (hit_cmp1) begin
      rdata_mux[CNT_W-1:0] = compare1_reg;
    end else if (hit_mask) begin
      rdata_mux[2:0] = int_mask_reg;
    end
  end

  assign PRDATA = (PSEL && !PWRITE) ? rdata_mux : 32'h0000_0000;

  // Checks: status flags and interrupt
  status_set_a: assert property (@(posedge CLK) disable iff (!RST_N) // R07
    CLK_EN && OVERFLOW
    |=> status_reg[ttfs_pkg::BIT_OVF])
    else $error("overflow flag not set");

  cmp1_set_a: assert property (@(posedge CLK) disable iff (!RST_N) // R08
    CLK_EN && match1
    |=> status_reg[ttfs_pkg::BIT_CMP1])
    else $error("compare one flag not set");

  cmp0_set_a: assert property (@(posedge CLK) disable iff (!RST_N) // R09
    CLK_EN && match0
    |=> status_reg[ttfs_pkg::BIT_CMP0])
    else $error("compare zero flag not set");

  flag_no_en_a: assert property (@(posedge CLK) disable iff (!RST_N) // R11
    CLK_EN && match0 && !irq_en_reg[ttfs_pkg::BIT_CMP0]
    |=> status_reg[ttfs_pkg::BIT_CMP0])
    else $error("flag gated by enable");

  read_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // R10
    rd_en && hit_stat && !OVERFLOW && !match0 && !match1
    |=> status_reg == 3'h0)
    else $error("status read did not clear");

  read_keep_a: assert property (@(posedge CLK) disable iff (!RST_N) // R16
    rd_en && hit_stat
    |=> status_reg == $past(events))
    else $error("event lost under clearing read");

  no_wr_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // R10 R16
    CLK_EN && !(rd_en && hit_stat)
    |=> (status_reg & $past(status_reg)) == $past(status_reg))
    else $error("flag lost without read");

  stat_read_a: assert property (@(posedge CLK) disable iff (!RST_N) // R10
    PSEL && !PWRITE && hit_stat
    |-> PRDATA == {29'h0, status_reg})
    else $error("status readback");

  status_freeze_a: assert property (@(posedge CLK) disable iff (!RST_N) // R10
    !CLK_EN
    |=> $stable(status_reg) && $stable(IRQ))
    else $error("status moved while frozen");

  irq_gate_a: assert property (@(posedge CLK) disable iff (!RST_N) // R12
    IRQ
    |-> |($past(status_next) & $past(irq_en_reg)))
    else $error("irq without enable");

  irq_level_a: assert property (@(posedge CLK) disable iff (!RST_N) // R12
    CLK_EN
    |=> IRQ == |(status_reg & $past(irq_en_reg) & $past(int_mask_reg)))
    else $error("irq level wrong");

  ien_wr_a: assert property (@(posedge CLK) disable iff (!RST_N) // R12
    wr_en && hit_ien
    |=> irq_en_reg == $past(PWDATA[2:0]))
    else $error("irq enable write lost");

  mask_wr_a: assert property (@(posedge CLK) disable iff (!RST_N) // R12
    wr_en && hit_mask
    |=> int_mask_reg == $past(PWDATA[2:0]))
    else $error("mask write lost");

  // Checks: output flop
  flop_set_a: assert property (@(posedge CLK) disable iff (!RST_N) // R05
    wr_en && hit_ctrl && PWDATA[1:0] == ttfs_pkg::CMD_SET
    |=> TIMER_OUT)
    else $error("set ignored");

  flop_clr_a: assert property (@(posedge CLK) disable iff (!RST_N) // R05
    wr_en && hit_ctrl && PWDATA[1:0] == ttfs_pkg::CMD_CLEAR
    |=> !TIMER_OUT)
    else $error("clear ignored");

  flop_inv_a: assert property (@(posedge CLK) disable iff (!RST_N) // R05
    wr_en && hit_ctrl && PWDATA[1:0] == ttfs_pkg::CMD_INVERT
    |=> TIMER_OUT != $past(TIMER_OUT))
    else $error("invert ignored");

  flop_keep_a: assert property (@(posedge CLK) disable iff (!RST_N) // R05 R15
    wr_en && hit_ctrl && PWDATA[1:0] == ttfs_pkg::CMD_READBACK && !toggle_any
    |=> TIMER_OUT == $past(TIMER_OUT))
    else $error("keep command moved flop");

  sw_wins_a: assert property (@(posedge CLK) disable iff (!RST_N) // R15
    wr_en && hit_ctrl && PWDATA[1:0] == ttfs_pkg::CMD_CLEAR && toggle_any
    |=> !TIMER_OUT)
    else $error("hardware toggle beat clear");

  cap1_tgl_a: assert property (@(posedge CLK) disable iff (!RST_N) // R01 R15
    CLK_EN && toggle_en_reg[3] && CAPTURE1_LOAD && !(wr_en && hit_ctrl)
    |=> TIMER_OUT != $past(TIMER_OUT))
    else $error("capture one toggle missed");

  cap0_tgl_a: assert property (@(posedge CLK) disable iff (!RST_N) // R02 R15
    CLK_EN && toggle_en_reg[2] && CAPTURE0_LOAD && !(wr_en && hit_ctrl)
    |=> TIMER_OUT != $past(TIMER_OUT))
    else $error("capture zero toggle missed");

  cmp1_tgl_a: assert property (@(posedge CLK) disable iff (!RST_N) // R03 R15
    CLK_EN && toggle_en_reg[1] && match1 && !(wr_en && hit_ctrl)
    |=> TIMER_OUT != $past(TIMER_OUT))
    else $error("compare one toggle missed");

  cmp0_tgl_a: assert property (@(posedge CLK) disable iff (!RST_N) // R04 R15
    CLK_EN && toggle_en_reg[0] && match0 && !(wr_en && hit_ctrl)
    |=> TIMER_OUT != $past(TIMER_OUT))
    else $error("compare zero toggle missed");

  no_tgl_a: assert property (@(posedge CLK) disable iff (!RST_N) // R01 R02 R03 R04
    CLK_EN && !toggle_any && !(wr_en && hit_ctrl)
    |=> TIMER_OUT == $past(TIMER_OUT))
    else $error("flop moved without cause");

  flop_freeze_a: assert property (@(posedge CLK) disable iff (!RST_N) // R05
    !CLK_EN
    |=> $stable(TIMER_OUT))
    else $error("flop moved while frozen");

  ctrl_wr_a: assert property (@(posedge CLK) disable iff (!RST_N) // R01 R02 R03 R04
    wr_en && hit_ctrl
    |=> toggle_en_reg == $past(PWDATA[5:2]))
    else $error("toggle enable write lost");

  // Checks: registers and snapshot
  cmd_read_a: assert property (@(posedge CLK) disable iff (!RST_N) // R06
    PSEL && !PWRITE && hit_ctrl
    |-> PRDATA[1:0] == ttfs_pkg::CMD_READBACK)
    else $error("command readback");

  snap_a: assert property (@(posedge CLK) disable iff (!RST_N) // R13
    PSEL && !PWRITE && hit_snap
    |-> PRDATA[CNT_W-1:0] == COUNTER)
    else $error("snapshot");

  cmp0_wr_a: assert property (@(posedge CLK) disable iff (!RST_N) // R14
    wr_en && hit_cmp0
    |=> compare0_reg == $past(PWDATA[CNT_W-1:0]))
    else $error("compare zero write lost");

  cmp1_wr_a: assert property (@(posedge CLK) disable iff (!RST_N) // R14
    wr_en && hit_cmp1
    |=> compare1_reg == $past(PWDATA[CNT_W-1:0]))
    else $error("compare one write lost");

  cfg_freeze_a: assert property (@(posedge CLK) disable iff (!RST_N) // R14
    !CLK_EN
    |=> $stable(compare0_reg) && $stable(compare1_reg) && $stable(toggle_en_reg))
    else $error("settings moved while frozen");
endmodule
`default_nettype wire

// ===== tb/testbench.sv
/*
  Self-checking bench for the timer toggle, flags and snapshot block.
  Assumes the zero-wait APB slave and one-cycle event strobes of ttfs_top.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        CLK, RST_N, CLK_EN, PSEL, PENABLE, PWRITE, OVERFLOW;
  logic        CAPTURE0_LOAD, CAPTURE1_LOAD, PREADY, PSLVERR, TIMER_OUT;
  logic        MATCH0, MATCH1, IRQ, e, flop;
  logic [15:0] COUNTER;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic [1:0]  cmds [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic [18:0] evs [4] = '{{3'h1, 16'h0100}, {3'h2, 16'h0100}, {3'h0, 16'h0010}, {3'h0, 16'h0020}};
  int          errors, cmp_count;

  ttfs_top i_ttfs_top (.CLK(CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .COUNTER(COUNTER),
    .CAPTURE0_LOAD(CAPTURE0_LOAD), .CAPTURE1_LOAD(CAPTURE1_LOAD), .OVERFLOW(OVERFLOW),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_OUT(TIMER_OUT),
    .MATCH0(MATCH0), .MATCH1(MATCH1), .IRQ(IRQ));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, x, s);
    end
  endtask

  task automatic conclude();
    $display("errors %0d, comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Strobes ride on the access phase so they can coincide with the access edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [2:0] ev);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    {OVERFLOW, CAPTURE1_LOAD, CAPTURE0_LOAD} <= ev;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    {OVERFLOW, CAPTURE1_LOAD, CAPTURE0_LOAD} <= 3'h0;
    @(negedge CLK);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 3'h0);
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0, 3'h0);
    chk(n, r, x);
  endtask

  // Match is a level, so the counter sits on the value for one cycle only
  task automatic evt(input logic [2:0] ev, input logic [15:0] c);
    @(posedge CLK);
    {OVERFLOW, CAPTURE1_LOAD, CAPTURE0_LOAD} <= ev;
    COUNTER <= c;
    @(negedge CLK);
    chk("match", {MATCH1, MATCH0}, {c == 16'h0020, c == 16'h0010});
    @(posedge CLK);
    {OVERFLOW, CAPTURE1_LOAD, CAPTURE0_LOAD} <= 3'h0;
    COUNTER <= 16'h0100;
    @(negedge CLK);
  endtask

  // Interrupt output is registered, so let it settle first
  task automatic irq_is(input logic x);
    repeat (2) @(negedge CLK);
    chk("irq", IRQ, x);
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    conclude();
  end

  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, CAPTURE0_LOAD, CAPTURE1_LOAD, OVERFLOW} = 7'h0;
    CLK_EN = 1'b1;
    COUNTER = 16'h0100;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    errors = 0;
    cmp_count = 0;
    flop = 1'b0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    chk("flop", TIMER_OUT, 32'h0);
    rd("ctrl", ttfs_pkg::OFF_FLOP_CTRL, 32'hc3);
    rd("status", ttfs_pkg::OFF_STATUS, 32'h0);
    rd("irq_en", ttfs_pkg::OFF_IRQ_EN, 32'h0);
    wr(ttfs_pkg::OFF_COMPARE0, 32'h10);
    wr(ttfs_pkg::OFF_COMPARE1, 32'h20);
    for (int i = 0; i < 4; i++) begin
      wr(ttfs_pkg::OFF_FLOP_CTRL, {30'h0, cmds[i]});
      flop = cmds[i][1] ? (cmds[i][0] & flop) : (cmds[i][0] | ~flop);
      chk("flop", TIMER_OUT, flop);
    end
    for (int p = 0; p < 2; p++) begin
      wr(ttfs_pkg::OFF_FLOP_CTRL, (p == 0) ? 32'h3f : 32'h03);
      rd("ctrl", ttfs_pkg::OFF_FLOP_CTRL, (p == 0) ? 32'hff : 32'hc3);
      for (int i = 0; i < 4; i++) begin
        evt(evs[i][18:16], evs[i][15:0]);
        flop = flop ^ (p == 0);
        chk("flop", TIMER_OUT, flop);
      end
      rd("status", ttfs_pkg::OFF_STATUS, 32'h3);
    end
    rd("status", ttfs_pkg::OFF_STATUS, 32'h0);
    evt(3'h4, 16'h0100);
    irq_is(1'b0);
    wr(ttfs_pkg::OFF_IRQ_EN, 32'h3);
    irq_is(1'b0);
    wr(ttfs_pkg::OFF_IRQ_EN, 32'h4);
    irq_is(1'b1);
    rd("irq_en", ttfs_pkg::OFF_IRQ_EN, 32'h4);
    wr(ttfs_pkg::OFF_INT_MASK, 32'h0);
    irq_is(1'b0);
    wr(ttfs_pkg::OFF_INT_MASK, 32'h7);
    wr(ttfs_pkg::OFF_STATUS, 32'h7);
    irq_is(1'b1);
    rd("status", ttfs_pkg::OFF_STATUS, 32'h4);
    irq_is(1'b0);
    acc(1'b0, ttfs_pkg::OFF_STATUS, 32'h0, 3'h4);
    chk("status", r, 32'h0);
    rd("status", ttfs_pkg::OFF_STATUS, 32'h4);
    @(posedge CLK);
    CLK_EN <= 1'b0;
    wr(ttfs_pkg::OFF_IRQ_EN, 32'h0);
    evt(3'h4, 16'h0010);
    @(posedge CLK);
    CLK_EN <= 1'b1;
    rd("irq_en", ttfs_pkg::OFF_IRQ_EN, 32'h4);
    rd("status", ttfs_pkg::OFF_STATUS, 32'h0);
    wr(ttfs_pkg::OFF_FLOP_CTRL, 32'h12);
    chk("flop", TIMER_OUT, 32'h0);
    acc(1'b1, ttfs_pkg::OFF_FLOP_CTRL, 32'h12, 3'h1);
    chk("flop", TIMER_OUT, 32'h0);
    wr(ttfs_pkg::OFF_FLOP_CTRL, 32'h17);
    evt(3'h1, 16'h0010);
    chk("flop", TIMER_OUT, 32'h1);
    @(posedge CLK);
    RST_N <= 1'b0;
    @(posedge CLK);
    RST_N <= 1'b1;
    chk("flop", TIMER_OUT, 32'h0);
    rd("ctrl", ttfs_pkg::OFF_FLOP_CTRL, 32'hc3);
    rd("compare0", ttfs_pkg::OFF_COMPARE0, 32'h0);
    @(posedge CLK);
    COUNTER <= 16'habcd;
    rd("snapshot", ttfs_pkg::OFF_SNAPSHOT, 32'h0000abcd);
    acc(1'b0, 8'h1c, 32'h0, 3'h0);
    chk("slverr", e, 32'h1);
    chk("unmapped", r, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
